// ### tb/buzzer_key_model.sv
// Far side: headset key, master clock source and buzzer transducer meter
`timescale 1ns/1ps
module buzzer_key_model (
    // Clock and control
    input  wire logic ref_clk,
    input  wire logic press,
    input  wire logic clear,
    // Pins
    input  wire logic buzzer_out,
    output logic      remote_key_in,
    output logic      mclk_in,
    // Meter
    output int        hi_count,
    output int        rise_count
);
    logic prev = 1'b0;
    // Line has a pull-up; a press pulls it low
    assign remote_key_in = press ? 1'b0 : 1'b1;
    // Runs far above the real rate so a tone period fits a short run
    initial begin
        mclk_in = 1'b0;
        forever #8 mclk_in = ~mclk_in;
    end
    always @(posedge ref_clk) begin
        hi_count <= clear ? 0 : hi_count + int'(buzzer_out === 1'b1);
        rise_count <= clear ? 0 : rise_count + int'(buzzer_out === 1'b1 && !prev);
        prev <= buzzer_out === 1'b1;
    end
endmodule // buzzer_key_model

// ### tb/buzzer_remote_ctrl_properties.sv
// Port-level checks for the buzzer and remote-key control block
`timescale 1ns/1ps
module buzzer_remote_ctrl_properties #(
    parameter int DEBOUNCE_CYCLES = 16
) (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Register port and context
    input wire logic       reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       power_down,
    // Outputs
    input wire logic       remote_key_out,
    input wire logic       buzzer_out,
    input wire logic       preamp_gain_sel,
    input wire logic       mic_bias_enable,
    input wire logic       tone_range_double,
    input wire logic       tone_range_half
);
    localparam logic [3:0] A_REM = buzzer_remote_pkg::REG_REMOTE_MISC;
    localparam logic [3:0] A_BUZ = buzzer_remote_pkg::REG_BUZZER;
    localparam logic [3:0] A_TON = buzzer_remote_pkg::REG_TONE_CTRL;
    logic [7:0] buz_r, buz_nxt, rem_r, rem_nxt, ton_r, ton_nxt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ====
    // Shadow copies of the written registers
    always_comb begin
        buz_nxt = (reg_wr && reg_addr == A_BUZ) ? reg_wdata : buz_r;
        rem_nxt = (reg_wr && reg_addr == A_REM) ? reg_wdata : rem_r;
        ton_nxt = (reg_wr && reg_addr == A_TON) ? reg_wdata : ton_r;
    end
    always_ff @(posedge ref_clk) begin
        buz_r <= reset ? 8'h00 : buz_nxt;
        rem_r <= reset ? 8'h00 : rem_nxt;
        ton_r <= reset ? 8'h00 : ton_nxt;
    end
    // ====
    // Properties
    sequence s_wr_rem; reg_wr && reg_addr == A_REM; endsequence
    sequence s_wr_buz; reg_wr && reg_addr == A_BUZ; endsequence
    property p_idle; !buz_r[7] |=> buzzer_out == $past(buz_r[6]); endproperty
    property p_pd; power_down |=> buzzer_out == $past(buz_r[6]); endproperty
    property p_zero_duty; buz_r[5:0] == 6'h00 |=> buzzer_out == $past(buz_r[6]); endproperty
    property p_no_tone_a; !ton_r[3] |=> buzzer_out == $past(buz_r[6]); endproperty
    property p_key_released;
        (!rem_r[7] && !rem_r[6]) [*3] |=> remote_key_out == $past(rem_r[5]);
    endproperty
    property p_gain_bias;
        s_wr_rem |=> mic_bias_enable == $past(reg_wdata[2]) && preamp_gain_sel == $past(reg_wdata[3]);
    endproperty
    property p_range;
        s_wr_rem |=> tone_range_double == $past(reg_wdata[1]) && tone_range_half == $past(reg_wdata[0]);
    endproperty
    // Detection was off before and after the write, so nothing can set the flag again
    property p_flag_clear;
        reg_wr && reg_addr == A_REM && !reg_wdata[7] && !rem_r[7] ##1 reg_addr == A_REM |=> !reg_rdata[4];
    endproperty
    property p_readback;
        s_wr_buz ##1 (!reg_wr && reg_addr == A_BUZ) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_idle: assert property (p_idle) else $error("buzzer not idle while off");
    a_pd: assert property (p_pd) else $error("buzzer not idle in power down");
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty not idle");
    a_no_tone_a: assert property (p_no_tone_a) else $error("buzzer active without tone A");
    a_key_released: assert property (p_key_released) else $error("key output wrong when off");
    a_gain_bias: assert property (p_gain_bias) else $error("gain or bias bit wrong");
    a_range: assert property (p_range) else $error("range bits wrong");
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write");
    a_readback: assert property (p_readback) else $error("buzzer register readback wrong");
endmodule // buzzer_remote_ctrl_properties

bind buzzer_remote_ctrl buzzer_remote_ctrl_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
    .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_down(power_down), .remote_key_out(remote_key_out),
    .buzzer_out(buzzer_out), .preamp_gain_sel(preamp_gain_sel), .mic_bias_enable(mic_bias_enable),
    .tone_range_double(tone_range_double), .tone_range_half(tone_range_half));

// ### tb/test_buzzer_remote_ctrl.sv
// Self-checking bench for the buzzer and remote-key control block
`timescale 1ns/1ps
module test_buzzer_remote_ctrl;
    typedef struct { logic [3:0] a; logic [7:0] d; logic [7:0] rd; logic [3:0] o; } row_t;
    logic       ref_clk, reset, reg_wr, power_down, press, clear, key_out, buz, gain, bias, dbl, half, key_in, mclk;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tone_a, tone_b;
    logic [1:0] rate;
    int         hi_count, rise_count, err_count, n_checks, cycles;
    int         pre [6] = '{1, 3, 4, 5, 1, 1};
    int         mul [6] = '{4, 4, 4, 4, 2, 1};
    logic [7:0] rng [6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h01};
    row_t rows [7] = '{'{4'ha, 8'h84, 8'h84, 4'h4}, '{4'ha, 8'h1b, 8'h0b, 4'hb}, '{4'ha, 8'h02, 8'h02, 4'h2},
                       '{4'ha, 8'h01, 8'h01, 4'h1}, '{4'hb, 8'hff, 8'hff, 4'h1}, '{4'h7, 8'h0c, 8'h0c, 4'h1},
                       '{4'h3, 8'h55, 8'h00, 4'h1}};
    buzzer_remote_ctrl #(.DEBOUNCE_CYCLES(16)) uut (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mclk_in(mclk),
        .mclk_rate_sel(rate), .tone_a_freq_reg(tone_a), .tone_b_freq_reg(tone_b), .power_down(power_down),
        .remote_key_in(key_in), .remote_key_out(key_out), .buzzer_out(buz), .preamp_gain_sel(gain),
        .mic_bias_enable(bias), .tone_range_double(dbl), .tone_range_half(half));
    buzzer_key_model u_far (.ref_clk(ref_clk), .press(press), .clear(clear), .buzzer_out(buz),
        .remote_key_in(key_in), .mclk_in(mclk), .hi_count(hi_count), .rise_count(rise_count));
    // ====
    // Tasks
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic near(input string what, input int exp, input int got, input int tol);
        n_checks++;
        if (got > exp + tol || got < exp - tol) begin
            err_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        repeat (2) @(negedge ref_clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask
    // Settle past one tone period at rate code 0 with doubled range, then meter a fixed window
    task automatic meter();
        repeat (600) @(negedge ref_clk);
        clear = 1'b1;
        @(negedge ref_clk);
        clear = 1'b0;
        repeat (4096) @(negedge ref_clk);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // ====
    // Clock and timeout
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            report_and_stop();
        end
    end
    // ====
    // Main sequence
    initial begin
        {reset, clear} = 2'b11;
        {reg_wr, power_down, press} = 3'b000;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        rate = 2'h0;
        tone_a = 8'hff;
        tone_b = 8'h40;
        wait_n(10);
        {reset, clear} = 2'b00;
        rd(4'ha, 8'h00);
        rd(4'hb, 8'h00);
        chk("pins", 8'h00, {4'h0, key_out, buz, gain, bias});
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].rd);
            chk("controls", {4'h0, rows[i].o}, {4'h0, gain, bias, dbl, half});
        end
        wr(4'h7, 8'h08);
        wr(4'hb, 8'ha0);
        for (int i = 0; i < 6; i++) begin
            rate = i < 4 ? 2'(i) : 2'h0;
            wr(4'ha, rng[i]);
            meter();
            near("tone periods", (4096 * mul[i] * 255) / (4 * pre[i] * 131072), rise_count, 1);
        end
        wr(4'ha, 8'h02);
        meter();
        near("high time", 1024, hi_count, 128);
        wr(4'hb, 8'hbf);
        meter();
        near("high time", 2016, hi_count, 128);
        wr(4'hb, 8'he0);
        meter();
        near("high time", 3072, hi_count, 128);
        wr(4'h7, 8'h0c);
        wr(4'hb, 8'ha0);
        meter();
        near("high time", 512, hi_count, 128);
        wr(4'h7, 8'h04);
        meter();
        near("high time", 0, hi_count, 0);
        chk("buzzer_out", 8'h00, {7'h00, buz});
        wr(4'h7, 8'h08);
        power_down = 1'b1;
        meter();
        near("high time", 0, hi_count, 0);
        chk("buzzer_out", 8'h00, {7'h00, buz});
        power_down = 1'b0;
        wr(4'hb, 8'h60);
        meter();
        near("high time", 4096, hi_count, 0);
        wr(4'ha, 8'hc0);
        press = 1'b1;
        wait_n(40);
        rd(4'ha, 8'hd0);
        press = 1'b0;
        wait_n(40);
        chk("remote_key_out", 8'h01, {7'h00, key_out});
        wr(4'ha, 8'hc0);
        wait_n(3);
        chk("remote_key_out", 8'h00, {7'h00, key_out});
        press = 1'b1;
        wait_n(8);
        press = 1'b0;
        wait_n(40);
        rd(4'ha, 8'hc0);
        wr(4'ha, 8'ha0);
        wait_n(3);
        chk("remote_key_out", 8'h01, {7'h00, key_out});
        press = 1'b1;
        wait_n(40);
        chk("remote_key_out", 8'h00, {7'h00, key_out});
        press = 1'b0;
        wr(4'ha, 8'h00);
        press = 1'b1;
        wait_n(40);
        rd(4'ha, 8'h00);
        press = 1'b0;
        // Reset in mid-run: buzzer was resting high, must return to reset values
        reset = 1'b1;
        wait_n(3);
        reset = 1'b0;
        rd(4'hb, 8'h00);
        rd(4'h7, 8'h00);
        chk("pins", 8'h00, {4'h0, key_out, buz, gain, bias});
        report_and_stop();
    end
endmodule // test_buzzer_remote_ctrl

// ### verilog/buzzer_remote_ctrl.sv
// Remote-key detection, misc audio control bits and PWM buzzer driver
// Operation
// - Key output inverted by polarity bit five
// - Default not inverted: press reads high
// - Flag bit four sets after debounced low
// - Remote register write clears flag
// - Bit three picks 0 or 20 dB
// - Bit two switches mic bias, off default
// - Range bits pick standard, halved, doubled steps
// - Buzzer enable drives PWM at tone A
// - Duty equals six-bit code times 0.78125%
// - Tone A only gives plain PWM
// - Both tones: PWM gated by tone B
// - Polarity bit six picks duty level
// - Disabled or powered down: rest at polarity
// - Master clock rate programmable, timing follows
// - Bit seven enables detection, off default
// - Bit six transparent or latched, debounced
// - Tone control bits select tone A, B
`timescale 1ns/1ps
module buzzer_remote_ctrl #(
    parameter int DEBOUNCE_CYCLES = buzzer_remote_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Register port from the serial control decoder
    input  wire logic       reg_wr,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Device context
    input  wire logic       mclk_in,
    input  wire logic [1:0] mclk_rate_sel,
    input  wire logic [7:0] tone_a_freq_reg,
    input  wire logic [7:0] tone_b_freq_reg,
    input  wire logic       power_down,
    // Pins
    input  wire logic       remote_key_in,
    output logic            remote_key_out,
    output logic            buzzer_out,
    // Analog control
    output logic            preamp_gain_sel,
    output logic            mic_bias_enable,
    output logic            tone_range_double,
    output logic            tone_range_half
);
    localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);

    if (DEBOUNCE_CYCLES < 1) begin : g_check
        $error("DEBOUNCE_CYCLES must be at least one");
    end

    // ========================================================
    // Registers
    logic [7:0] remote_misc_ctrl_reg_r;
    logic [7:0] remote_misc_ctrl_reg_nxt;
    logic [7:0] buzzer_ctrl_reg_r;
    logic [7:0] buzzer_ctrl_reg_nxt;
    logic [7:0] tone_control_reg_r;
    logic [7:0] tone_control_reg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Synchronisers, prescaler, debounce
    logic [1:0]      key_sync_r;
    logic [1:0]      mclk_sync_r;
    logic            mclk_prev_r;
    logic [2:0]      pre_cnt_r;
    logic [2:0]      pre_cnt_nxt;
    logic            tick_r;
    logic            tick_nxt;
    logic [DB_W-1:0] db_cnt_r;
    logic [DB_W-1:0] db_cnt_nxt;
    logic            pressed_r;
    logic            pressed_nxt;
    logic            key_out_r;
    logic            key_out_nxt;
    logic            buz_r;
    logic            buz_nxt;
    logic [2:0]      prescale;
    logic            mclk_rise;
    logic            key_low;
    logic            press_event;
    logic            remote_wr;

    tone_if tone_a ();
    tone_if tone_b ();

    // ========================================================
    // Register access
    always_comb begin
        remote_wr                = reg_wr && (reg_addr == buzzer_remote_pkg::REG_REMOTE_MISC);
        remote_misc_ctrl_reg_nxt = remote_misc_ctrl_reg_r;
        buzzer_ctrl_reg_nxt      = buzzer_ctrl_reg_r;
        tone_control_reg_nxt     = tone_control_reg_r;
        if (remote_wr) begin
            remote_misc_ctrl_reg_nxt = reg_wdata;
            remote_misc_ctrl_reg_nxt[buzzer_remote_pkg::REM_FLAG_BIT] = 1'b0;
        end
        // A detection in the same cycle as a clearing write keeps the flag
        if (press_event) begin
            remote_misc_ctrl_reg_nxt[buzzer_remote_pkg::REM_FLAG_BIT] = 1'b1;
        end
        if (reg_wr && (reg_addr == buzzer_remote_pkg::REG_BUZZER)) begin
            buzzer_ctrl_reg_nxt = reg_wdata;
        end
        if (reg_wr && (reg_addr == buzzer_remote_pkg::REG_TONE_CTRL)) begin
            tone_control_reg_nxt = reg_wdata;
        end
        case (reg_addr)
            buzzer_remote_pkg::REG_REMOTE_MISC: rdata_nxt = remote_misc_ctrl_reg_r;
            buzzer_remote_pkg::REG_BUZZER:      rdata_nxt = buzzer_ctrl_reg_r;
            buzzer_remote_pkg::REG_TONE_CTRL:   rdata_nxt = tone_control_reg_r;
            default:                            rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            remote_misc_ctrl_reg_r <= buzzer_remote_pkg::REMOTE_MISC_RESET;
            buzzer_ctrl_reg_r      <= buzzer_remote_pkg::BUZZER_RESET;
            tone_control_reg_r     <= buzzer_remote_pkg::TONE_CTRL_RESET;
            rdata_r                <= 8'h00;
        end else begin
            remote_misc_ctrl_reg_r <= remote_misc_ctrl_reg_nxt;
            buzzer_ctrl_reg_r      <= buzzer_ctrl_reg_nxt;
            tone_control_reg_r     <= tone_control_reg_nxt;
            rdata_r                <= rdata_nxt;
        end
    end

    // ========================================================
    // Master clock edge and prescaler to the 512 kHz base tick
    always_comb begin
        case (mclk_rate_sel)
            buzzer_remote_pkg::MCLK_512K:  prescale = buzzer_remote_pkg::PRESCALE_512K;
            buzzer_remote_pkg::MCLK_1536K: prescale = buzzer_remote_pkg::PRESCALE_1536K;
            buzzer_remote_pkg::MCLK_2048K: prescale = buzzer_remote_pkg::PRESCALE_2048K;
            buzzer_remote_pkg::MCLK_2560K: prescale = buzzer_remote_pkg::PRESCALE_2560K;
            default:                       prescale = buzzer_remote_pkg::PRESCALE_512K;
        endcase
        mclk_rise   = mclk_sync_r[1] && !mclk_prev_r;
        pre_cnt_nxt = pre_cnt_r;
        tick_nxt    = 1'b0;
        if (mclk_rise) begin
            if (pre_cnt_r + 3'h1 >= prescale) begin
                pre_cnt_nxt = 3'h0;
                tick_nxt    = 1'b1;
            end else begin
                pre_cnt_nxt = pre_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mclk_sync_r <= 2'b00;
            mclk_prev_r <= 1'b0;
            pre_cnt_r   <= 3'h0;
            tick_r      <= 1'b0;
        end else begin
            mclk_sync_r <= {mclk_sync_r[0], mclk_in};
            mclk_prev_r <= mclk_sync_r[1];
            pre_cnt_r   <= pre_cnt_nxt;
            tick_r      <= tick_nxt;
        end
    end

    // ========================================================
    // Remote key debounce; a low level on the input means pressed
    always_comb begin
        key_low     = !key_sync_r[1];
        db_cnt_nxt  = '0;
        pressed_nxt = pressed_r;
        press_event = 1'b0;
        if (!remote_misc_ctrl_reg_r[buzzer_remote_pkg::REM_ENABLE_BIT]) begin
            pressed_nxt = 1'b0;
        end else if (key_low != pressed_r) begin
            // Level must hold without a break for the whole interval
            if (db_cnt_r >= DB_W'(DEBOUNCE_CYCLES - 1)) begin
                pressed_nxt = key_low;
                press_event = key_low;
            end else begin
                db_cnt_nxt = db_cnt_r + DB_W'(1);
            end
        end
        if (remote_misc_ctrl_reg_r[buzzer_remote_pkg::REM_LATCH_BIT]) begin
            key_out_nxt = remote_misc_ctrl_reg_r[buzzer_remote_pkg::REM_FLAG_BIT];
        end else begin
            key_out_nxt = pressed_r;
        end
        key_out_nxt = key_out_nxt ^ remote_misc_ctrl_reg_r[buzzer_remote_pkg::REM_INVERT_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            key_sync_r <= 2'b11;
            db_cnt_r   <= '0;
            pressed_r  <= 1'b0;
            key_out_r  <= 1'b0;
        end else begin
            key_sync_r <= {key_sync_r[0], remote_key_in};
            db_cnt_r   <= db_cnt_nxt;
            pressed_r  <= pressed_nxt;
            key_out_r  <= key_out_nxt;
        end
    end

    // ========================================================
    // Tone generators
    assign tone_a.tick         = tick_r;
    assign tone_a.range_double = remote_misc_ctrl_reg_r[buzzer_remote_pkg::RANGE_DOUBLE_BIT];
    assign tone_a.range_half   = remote_misc_ctrl_reg_r[buzzer_remote_pkg::RANGE_HALF_BIT];
    assign tone_a.freq         = tone_a_freq_reg;
    assign tone_b.tick         = tick_r;
    assign tone_b.range_double = remote_misc_ctrl_reg_r[buzzer_remote_pkg::RANGE_DOUBLE_BIT];
    assign tone_b.range_half   = remote_misc_ctrl_reg_r[buzzer_remote_pkg::RANGE_HALF_BIT];
    assign tone_b.freq         = tone_b_freq_reg;

    tone_phase_gen u_tone_a (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tone    (tone_a)
    );

    tone_phase_gen u_tone_b (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tone    (tone_b)
    );

    // ========================================================
    // Buzzer PWM; the duty code counts active slots out of 128
    always_comb begin
        logic active;
        logic polarity;
        active   = 1'b0;
        polarity = buzzer_ctrl_reg_r[buzzer_remote_pkg::BUZ_POLARITY_BIT];
        active   = ({1'b0, tone_a.slot} <
                    {2'b00, buzzer_ctrl_reg_r[buzzer_remote_pkg::DUTY_MSB:0]});
        // Tone B as a gate: while its square is low the buzzer rests
        if (tone_control_reg_r[buzzer_remote_pkg::TONE_B_SEL_BIT] && !tone_b.square) begin
            active = 1'b0;
        end
        if (!buzzer_ctrl_reg_r[buzzer_remote_pkg::BUZ_ENABLE_BIT] || power_down ||
            !tone_control_reg_r[buzzer_remote_pkg::TONE_A_SEL_BIT]) begin
            active = 1'b0;
        end
        buz_nxt = active ^ polarity;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            buz_r <= 1'b0;
        end else begin
            buz_r <= buz_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign reg_rdata         = rdata_r;
    assign remote_key_out    = key_out_r;
    assign buzzer_out        = buz_r;
    assign preamp_gain_sel   = remote_misc_ctrl_reg_r[buzzer_remote_pkg::PREAMP_GAIN_BIT];
    assign mic_bias_enable   = remote_misc_ctrl_reg_r[buzzer_remote_pkg::MIC_BIAS_BIT];
    assign tone_range_double = remote_misc_ctrl_reg_r[buzzer_remote_pkg::RANGE_DOUBLE_BIT];
    assign tone_range_half   = remote_misc_ctrl_reg_r[buzzer_remote_pkg::RANGE_HALF_BIT];
endmodule // buzzer_remote_ctrl

// ### verilog/buzzer_remote_pkg.sv
// Constants shared by the buzzer PWM and remote-key detection logic
package buzzer_remote_pkg;

    // ========================================================
    // Register numbers on the internal control port
    localparam logic [3:0] REG_TONE_CTRL   = 4'h7;
    localparam logic [3:0] REG_REMOTE_MISC = 4'ha;
    localparam logic [3:0] REG_BUZZER      = 4'hb;

    // ========================================================
    // Remote/misc control register fields
    localparam int REM_ENABLE_BIT   = 7;
    localparam int REM_LATCH_BIT    = 6;
    localparam int REM_INVERT_BIT   = 5;
    localparam int REM_FLAG_BIT     = 4;
    localparam int PREAMP_GAIN_BIT  = 3;
    localparam int MIC_BIAS_BIT     = 2;
    localparam int RANGE_DOUBLE_BIT = 1;
    localparam int RANGE_HALF_BIT   = 0;
    // Gain bit 0 selects 20 dB, so the reset value gives 20 dB
    localparam logic [7:0] REMOTE_MISC_RESET = 8'h00;

    // ========================================================
    // Buzzer control register fields
    localparam int BUZ_ENABLE_BIT   = 7;
    localparam int BUZ_POLARITY_BIT = 6;
    localparam int DUTY_MSB         = 5;
    localparam logic [7:0] BUZZER_RESET = 8'h00;

    // ========================================================
    // Tone control register fields
    localparam int TONE_A_SEL_BIT = 3;
    localparam int TONE_B_SEL_BIT = 2;
    localparam logic [7:0] TONE_CTRL_RESET = 8'h00;

    // ========================================================
    // Tone timing: a 512 kHz base tick and a 17-bit phase accumulator
    localparam int PHASE_W     = 17;
    localparam int SLOT_W      = 7;
    localparam int FREQ_W      = 8;
    localparam int DUTY_W      = 6;
    localparam int BASE_TICK_KHZ = 512;

    // Master clock prescale to reach the base tick, per rate code
    localparam logic [2:0] PRESCALE_512K  = 3'h1;
    localparam logic [2:0] PRESCALE_1536K = 3'h3;
    localparam logic [2:0] PRESCALE_2048K = 3'h4;
    localparam logic [2:0] PRESCALE_2560K = 3'h5;
    localparam logic [1:0] MCLK_512K      = 2'h0;
    localparam logic [1:0] MCLK_1536K     = 2'h1;
    localparam logic [1:0] MCLK_2048K     = 2'h2;
    localparam logic [1:0] MCLK_2560K     = 2'h3;

    // ========================================================
    // Debounce time on the key input
    localparam int CLK_FREQ_MHZ     = 250;
    localparam int DEBOUNCE_TIME_US = 50000;
    localparam int DEBOUNCE_CYCLES  = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;

endpackage

// ### verilog/tone_if.sv
// Connection between the top and one tone phase generator
`timescale 1ns/1ps
interface tone_if;
    logic                                   tick;
    logic                                   range_double;
    logic                                   range_half;
    logic [buzzer_remote_pkg::FREQ_W-1:0]   freq;
    logic [buzzer_remote_pkg::SLOT_W-1:0]   slot;
    logic                                   square;

    modport gen  (input tick, input range_double, input range_half, input freq,
                  output slot, output square);
    modport user (output tick, output range_double, output range_half, output freq,
                  input slot, input square);
endinterface

// ### verilog/tone_phase_gen.sv
// Phase accumulator producing one tone's square wave and PWM slot index
`timescale 1ns/1ps
module tone_phase_gen (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Tone link
    tone_if.gen       tone
);
    logic [buzzer_remote_pkg::PHASE_W-1:0] acc_r;
    logic [buzzer_remote_pkg::PHASE_W-1:0] acc_nxt;
    logic [buzzer_remote_pkg::PHASE_W-1:0] step;

    // ========================================================
    // Step size: halved N, standard 2N, doubled 4N per base tick
    always_comb begin
        step = {{(buzzer_remote_pkg::PHASE_W-buzzer_remote_pkg::FREQ_W){1'b0}}, tone.freq};
        if (tone.range_double && !tone.range_half) begin
            step = step << 2;
        end else if (tone.range_half && !tone.range_double) begin
            step = step;
        end else begin
            step = step << 1;
        end
        acc_nxt = acc_r;
        if (tone.tick) begin
            acc_nxt = acc_r + step;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Top bits split one period into 128 slots
    assign tone.slot   = acc_r[buzzer_remote_pkg::PHASE_W-1 -: buzzer_remote_pkg::SLOT_W];
    assign tone.square = acc_r[buzzer_remote_pkg::PHASE_W-1];
endmodule // tone_phase_gen
